/* File: design/srlo_pkg.sv */
// constants and types for the serial read-out lane block
package srlo_pkg;
   localparam int WORD_W = 22;
   localparam int LANE_N = 4;
   localparam logic [1:0] MODE_DEFAULT = 2'h0;
   localparam logic [1:0] LAUNCH_EARLY = 2'h1;
   localparam logic [1:0] LAUNCH_CLKOUT = 2'h3;
   localparam logic [1:0] LANES_TWO = 2'h2;
   localparam logic [1:0] LANES_FOUR = 2'h3;
   localparam int LAUNCH_LSB = 0;
   localparam int LANES_LSB = 2;
   localparam int RATE_BIT = 4;
   localparam logic [7:0] OCTL_RESET = 8'h00;
   localparam logic [7:0] OCTL_DAISY_STD = 8'h00;
   localparam logic [7:0] OCTL_DAISY_EARLY = 8'h01;
   localparam logic [3:0] LANES_IDLE = 4'h0;
   // sync reset image {sclk, cs_n, sdi}: clock low, chip select idle high
   localparam logic [2:0] PINS_RESET = 3'h2;
   typedef enum logic [1:0] {SRLO_IDLE = 2'b01, SRLO_FRAME = 2'b10} srlo_state_e;
endpackage

/* File: design/srlo_pins_if.sv */
// synchronised host pins and their edge strobes
`timescale 1ns/1ps
`default_nettype none
interface srlo_pins_if;
   logic sclk_s;
   logic cs_n_s;
   logic sdi_s;
   logic sclk_rise;
   logic sclk_fall;
   logic cs_fall;
   logic cs_rise;
   modport drv (output sclk_s, cs_n_s, sdi_s, sclk_rise, sclk_fall, cs_fall, cs_rise);
   modport dst (input sclk_s, cs_n_s, sdi_s, sclk_rise, sclk_fall, cs_fall, cs_rise);
endinterface
`default_nettype wire

/* File: design/srlo_pin_sync.sv */
// two-stage synchroniser and edge finder for the host pins
`timescale 1ns/1ps
`default_nettype none
module srlo_pin_sync (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdi,
   srlo_pins_if.drv pins
);
   logic [2:0] meta_r;
   logic [2:0] sync_r;
   logic [2:0] last_r;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_r <= srlo_pkg::PINS_RESET;
         sync_r <= srlo_pkg::PINS_RESET;
         last_r <= srlo_pkg::PINS_RESET;
      end else begin
         meta_r <= {sclk, cs_n, sdi};
         sync_r <= meta_r;
         last_r <= sync_r;
      end
   end

   assign pins.sclk_s = sync_r[2];
   assign pins.cs_n_s = sync_r[1];
   assign pins.sdi_s = sync_r[0];
   assign pins.sclk_rise = sync_r[2] & ~last_r[2];
   assign pins.sclk_fall = ~sync_r[2] & last_r[2];
   assign pins.cs_fall = ~sync_r[1] & last_r[1];
   assign pins.cs_rise = sync_r[1] & ~last_r[1];
endmodule // srlo_pin_sync
`default_nettype wire

/* File: design/srlo_readout.sv */
// serial read-out shifter with lane width, early launch and fill options
`timescale 1ns/1ps
`default_nettype none
module srlo_readout (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic sdi,
   input wire logic [21:0] data_word,
   input wire logic [7:0] input_control_reg,
   input wire logic [7:0] output_control_reg,
   output logic [3:0] serial_out_lanes,
   output logic ready_strobe_pin,
   output logic frame_active
);
   // ****************************************
   // decoding
   // ****************************************
   function automatic logic [3:0] lane_bits(input logic [21:0] s, input logic [1:0] cnt);
      logic [3:0] r;
      r = srlo_pkg::LANES_IDLE;
      unique case (cnt)
         srlo_pkg::LANES_TWO: r = {2'h0, s[srlo_pkg::WORD_W-1], s[srlo_pkg::WORD_W-2]};
         srlo_pkg::LANES_FOUR: r = s[srlo_pkg::WORD_W-1 -: 4];
         default: r = {3'h0, s[srlo_pkg::WORD_W-1]};
      endcase
      return r;
   endfunction

   srlo_pins_if pins ();
   srlo_pin_sync u_sync (
      .clk(clk),
      .rst_n(rst_n),
      .sclk(sclk),
      .cs_n(cs_n),
      .sdi(sdi),
      .pins(pins)
   );

   srlo_pkg::srlo_state_e state_r;
   srlo_pkg::srlo_state_e state_nxt;
   logic [1:0] mode_r;
   logic [7:0] octl_r;
   logic [21:0] shreg_r;
   logic [21:0] shreg_nxt;
   logic sdi_cap_r;
   logic first_r;

   wire [1:0] launch_sel = octl_r[srlo_pkg::LAUNCH_LSB +: 2];
   wire [1:0] lane_cnt = octl_r[srlo_pkg::LANES_LSB +: 2];
   wire in_frame = (state_r == srlo_pkg::SRLO_FRAME);
   wire frame_nxt = (state_nxt == srlo_pkg::SRLO_FRAME);
   wire is_clk_out = (launch_sel == srlo_pkg::LAUNCH_CLKOUT);
   wire early = (launch_sel == srlo_pkg::LAUNCH_EARLY) & ~mode_r[0];
   wire launch_rise = mode_r[0] ^ mode_r[1];
   wire launch_edge = launch_rise ? pins.sclk_rise : pins.sclk_fall;
   wire capture_edge = launch_rise ? pins.sclk_fall : pins.sclk_rise;
   wire clk_out_edge = pins.sclk_rise | (octl_r[srlo_pkg::RATE_BIT] & pins.sclk_fall);
   wire launch_ev = is_clk_out ? clk_out_edge : (early ? capture_edge : launch_edge);
   wire skip = first_r & mode_r[0] & ~is_clk_out;
   wire daisy = (octl_r == srlo_pkg::OCTL_DAISY_STD) | (octl_r == srlo_pkg::OCTL_DAISY_EARLY);
   wire fill = daisy & (early ? pins.sdi_s : sdi_cap_r);
   wire do_shift = in_frame & launch_ev & ~skip;
   logic [21:0] shifted;

   // ****************************************
   // shift and lane selection
   // ****************************************
   always_comb begin
      unique case (lane_cnt)
         srlo_pkg::LANES_TWO: shifted = {shreg_r[srlo_pkg::WORD_W-3:0], 2'h0};
         srlo_pkg::LANES_FOUR: shifted = {shreg_r[srlo_pkg::WORD_W-5:0], 4'h0};
         default: shifted = {shreg_r[srlo_pkg::WORD_W-2:0], fill};
      endcase
   end

   assign shreg_nxt = pins.cs_fall ? data_word : (do_shift ? shifted : shreg_r);
   assign state_nxt = pins.cs_fall ? srlo_pkg::SRLO_FRAME : (pins.cs_rise ? srlo_pkg::SRLO_IDLE : state_r);

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_r <= srlo_pkg::SRLO_IDLE;
         mode_r <= srlo_pkg::MODE_DEFAULT;
         octl_r <= srlo_pkg::OCTL_RESET;
      end else begin
         state_r <= state_nxt;
         if (pins.cs_rise) begin
            mode_r <= input_control_reg[1:0];
            octl_r <= output_control_reg;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         shreg_r <= '0;
         sdi_cap_r <= 1'b0;
         first_r <= 1'b0;
      end else begin
         shreg_r <= shreg_nxt;
         if (in_frame & capture_edge)
            sdi_cap_r <= pins.sdi_s;
         first_r <= pins.cs_fall | (first_r & ~(in_frame & launch_ev));
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         serial_out_lanes <= srlo_pkg::LANES_IDLE;
         ready_strobe_pin <= 1'b0;
         frame_active <= 1'b0;
      end else begin
         serial_out_lanes <= frame_nxt ? lane_bits(shreg_nxt, lane_cnt) : srlo_pkg::LANES_IDLE;
         ready_strobe_pin <= frame_nxt & is_clk_out & pins.sclk_s;
         frame_active <= frame_nxt;
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence frame_open_s;
      pins.cs_fall && !is_clk_out;
   endsequence

   sequence msb_out_s;
      serial_out_lanes[0] == $past(data_word[srlo_pkg::WORD_W-1]);
   endsequence

   sequence std_shift_s;
      in_frame && !early && !is_clk_out && launch_edge && !skip;
   endsequence

   sequence word_moved_s;
      shreg_r == $past(shifted);
   endsequence

   strobe_low_a: assert property (in_frame && !is_clk_out |-> !ready_strobe_pin)
      else $error("ready strobe high in spi frame");
   msb_first_a: assert property (frame_open_s and lane_cnt[1] == 1'b0 |=> msb_out_s)
      else $error("msb not presented at frame start");
   early_ignored_a: assert property (in_frame && mode_r[0] && !is_clk_out && capture_edge |=> $stable(shreg_r))
      else $error("shift on capture edge in protocol 01 or 11");
   early_shift_a: assert property (in_frame && early && capture_edge |=> shreg_r == $past(shifted))
      else $error("early launch missed capture edge");
   daisy_pass_a: assert property (do_shift && daisy && !early |=> shreg_r[0] == $past(sdi_cap_r))
      else $error("daisy data not passed");
   zero_fill_a: assert property (do_shift && !daisy |=> shreg_r[0] == 1'b0)
      else $error("non-zero fill after word");
   lane_map_a: assert property (in_frame && !pins.cs_rise |-> serial_out_lanes == lane_bits(shreg_r, lane_cnt))
      else $error("lane mapping wrong");
   quad_lanes_a: assert property (in_frame && lane_cnt == srlo_pkg::LANES_FOUR |->
      serial_out_lanes == shreg_r[srlo_pkg::WORD_W-1 -: srlo_pkg::LANE_N])
      else $error("quad lanes wrong");
   unused_low_a: assert property (in_frame && lane_cnt == srlo_pkg::LANES_TWO |-> serial_out_lanes[3:2] == 2'h0)
      else $error("unused lane driven");
   default_mode_a: assert property ($past(!rst_n) |-> mode_r == srlo_pkg::MODE_DEFAULT)
      else $error("protocol not default after reset");
   proto_latch_a: assert property (pins.cs_rise |=> mode_r == $past(input_control_reg[1:0]))
      else $error("protocol not taken at frame end");
   out_clock_a: assert property (in_frame && is_clk_out && !pins.cs_rise |=> ready_strobe_pin == $past(pins.sclk_s))
      else $error("output clock not following serial clock");

   // ****************************************
   // lane and fill checks
   // ****************************************
   dual_lanes_a: assert property (in_frame && lane_cnt == srlo_pkg::LANES_TWO |->
      serial_out_lanes[1:0] == shreg_r[srlo_pkg::WORD_W-1 -: 2])
      else $error("dual lanes wrong");
   single_lane_a: assert property (in_frame && lane_cnt[1] == 1'b0 |-> serial_out_lanes[3:1] == 3'h0)
      else $error("single lane mode drives extra lanes");
   idle_lanes_a: assert property (!in_frame |-> serial_out_lanes == srlo_pkg::LANES_IDLE)
      else $error("lanes driven outside frame");
   quad_fill_a: assert property (do_shift && lane_cnt == srlo_pkg::LANES_FOUR |=>
      shreg_r[srlo_pkg::LANE_N-1:0] == srlo_pkg::LANES_IDLE)
      else $error("quad shift filled non-zero");
   daisy_early_a: assert property (do_shift && daisy && early |=> shreg_r[0] == $past(pins.sdi_s))
      else $error("early daisy data not passed");
   capture_in_a: assert property (in_frame && capture_edge |=> sdi_cap_r == $past(pins.sdi_s))
      else $error("input bit not captured");

   // ****************************************
   // protocol and frame checks
   // ****************************************
   std_shift_a: assert property (std_shift_s |=> word_moved_s)
      else $error("standard launch edge missed");
   first_hold_a: assert property (in_frame && skip && launch_ev |=> $stable(shreg_r))
      else $error("first launch edge shifted in protocol 01 or 11");
   early_off_a: assert property (mode_r[0] |-> !early)
      else $error("early launch active in protocol 01 or 11");
   idle_strobe_a: assert property (!in_frame |-> !ready_strobe_pin)
      else $error("ready strobe high outside frame");
   octl_latch_a: assert property (pins.cs_rise |=> octl_r == $past(output_control_reg))
      else $error("output control not taken at frame end");
   octl_hold_a: assert property (!pins.cs_rise |=> $stable(octl_r))
      else $error("output control changed inside frame");
   mode_hold_a: assert property (!pins.cs_rise |=> $stable(mode_r))
      else $error("protocol changed away from frame end");
   frame_open_a: assert property (frame_open_s |=> frame_active)
      else $error("frame flag not raised");
endmodule // srlo_readout
`default_nettype wire

/* File: dv/srlo_host_model.sv */
// host master model driving the serial pins and logging the lanes
`timescale 1ns/1ps
`default_nettype none
module srlo_host_model (
   input wire logic clk,
   input wire logic [3:0] lanes,
   input wire logic rdy,
   input wire logic act,
   output logic sclk,
   output logic cs_n,
   output logic sdi
);
   logic [3:0] lane_log [0:63];
   logic rdy_log [0:63];
   logic sck_log [0:63];
   logic act_log [0:63];
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      sdi = 1'b0;
   end
   // one read frame of n clocks, 100 ns half period, lanes logged before each edge
   task automatic frame(input int n, input logic cpol);
      @(negedge clk);
      sclk = cpol;
      repeat (4) @(negedge clk);
      cs_n = 1'b0;
      sdi = 1'b1;
      for (int k = 0; k <= 2 * n; k++) begin
         repeat (4) @(negedge clk);
         lane_log[k] = lanes;
         rdy_log[k] = rdy;
         sck_log[k] = sclk;
         act_log[k] = act;
         if (k < 2 * n) begin
            sclk = ~sclk;
         end
      end
      cs_n = 1'b1;
      sdi = 1'b0;
      repeat (8) @(negedge clk);
   endtask
endmodule // srlo_host_model
`default_nettype wire

/* File: dv/serial_readout_lane_options_tb.sv */
// self-checking bench for the read-out lane block
`timescale 1ns/1ps
`default_nettype none
module serial_readout_lane_options_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [21:0] word = 22'h000000;
   logic [7:0] ictl = 8'h00;
   logic [7:0] octl = 8'h00;
   logic sclk, cs_n, sdi, rdy, fact;
   logic [3:0] lanes;
   logic [1:0] ap;
   logic [7:0] ao;
   logic [31:0] lfsr = 32'h6F3E016B;
   logic [7:0] otab [0:7] = '{8'h00, 8'h01, 8'h08, 8'h09, 8'h0C, 8'h0D, 8'h03, 8'h13};
   int n_mismatch = 0;
   int checks = 0;
   always #12.5 clk = ~clk;
   srlo_readout u_srlo_readout (.clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .sdi(sdi), .data_word(word),
      .input_control_reg(ictl), .output_control_reg(octl), .serial_out_lanes(lanes), .ready_strobe_pin(rdy),
      .frame_active(fact));
   srlo_host_model u_srlo_host_model (.clk(clk), .lanes(lanes), .rdy(rdy), .act(fact), .sclk(sclk), .cs_n(cs_n),
      .sdi(sdi));
   task automatic cmp4(input logic [3:0] got, input logic [3:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cmp1(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   function automatic logic [31:0] nxt(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   // expected lanes at log point k of a frame
   function automatic logic [3:0] elan(input logic [1:0] p, input logic [7:0] o, input int k);
      int w;
      int g;
      int i;
      logic [3:0] r;
      w = o[3] ? (o[2] ? 4 : 2) : 1;
      if (o[1:0] == srlo_pkg::LAUNCH_CLKOUT) begin
         g = o[srlo_pkg::RATE_BIT] ? k : (p[1] ? k / 2 : (k + 1) / 2);
      end else begin
         g = p[0] ? (k - 1) / 2 : o[1:0] == srlo_pkg::LAUNCH_EARLY ? (k + 1) / 2 : k / 2;
      end
      r = 4'h0;
      for (int j = 0; j < w; j++) begin
         i = 21 - w * g - (w - 1 - j);
         r[j] = i >= 0 ? word[i] : (o == srlo_pkg::OCTL_DAISY_STD || o == srlo_pkg::OCTL_DAISY_EARLY);
      end
      return r;
   endfunction
   // one frame under the active setup, loading the next setup at its end
   task automatic run(input logic [1:0] np, input logic [7:0] no);
      int w;
      int n;
      lfsr = nxt(lfsr);
      word = lfsr[21:0];
      ictl = {6'h00, np};
      octl = no;
      w = ao[3] ? (ao[2] ? 4 : 2) : 1;
      n = 20 / w + (lfsr[31] ? 4 / w + 1 : 0);
      u_srlo_host_model.frame(n, ap[1]);
      for (int k = 0; k <= 2 * n; k++) begin
         cmp4(u_srlo_host_model.lane_log[k], elan(ap, ao, k));
         cmp1(u_srlo_host_model.rdy_log[k], ao[1:0] == srlo_pkg::LAUNCH_CLKOUT && u_srlo_host_model.sck_log[k]);
         cmp1(u_srlo_host_model.act_log[k], 1'b1);
      end
      cmp4(lanes, srlo_pkg::LANES_IDLE);
      cmp1(fact, 1'b0);
      ap = np;
      ao = no;
   endtask
   task automatic print_verdict();
      $display("mismatches %0d checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      ap = srlo_pkg::MODE_DEFAULT;
      ao = srlo_pkg::OCTL_RESET;
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      cmp4(lanes, srlo_pkg::LANES_IDLE);
      for (int i = 0; i < 40; i++) begin
         lfsr = nxt(lfsr);
         run(i < 32 ? i[1:0] : lfsr[1:0], otab[i < 32 ? i / 4 : lfsr[7:5]]);
      end
      rst_n = 1'b0;
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      cmp4(lanes, srlo_pkg::LANES_IDLE);
      cmp1(fact, 1'b0);
      ap = srlo_pkg::MODE_DEFAULT;
      ao = srlo_pkg::OCTL_RESET;
      run(2'h1, 8'h0D);
      run(2'h2, 8'h0D);
      print_verdict();
   end
   initial begin
      #1000000;
      n_mismatch++;
      print_verdict();
   end
endmodule // serial_readout_lane_options_tb
`default_nettype wire
